//--- hdl/stm_matcher.sv
// sequential trigger matcher with ahb-lite register slave
////////////////////////////////////////////////////////////////////////////////
// Function
// - trigger width is a parameter, 1 to 40
// - chain of one to three patterns
// - post-trigger sampling starts after last match
// - length one: only pattern one counts
// - length two: pattern two on later clock
// - length three: patterns one, two, three in order
// - pattern bit n compares trigger channel n
// - value, edge and don't-care masks per pattern
// - don't-care channel excluded from match
// - rising edge matches on low-to-high cycle
// - level channels match while level holds
// - all don't-care pattern matches at once
// - and mode: every cared channel must match
// - or mode: any cared channel matches
// - and/or chosen per pattern
//
// Design decisions made here: the address map and the AHB-Lite slave port.
module stm_matcher
  import stm_pkg::*;
#(
  parameter int TRIG_W = 40
) (
  input  wire logic              hclk,        // bus and trigger clock
  input  wire logic              hresetn,     // async reset, low active
  input  wire logic              hsel,        // slave select
  input  wire logic [11:0]       haddr,       // byte address
  input  wire logic [1:0]        htrans,      // transfer type
  input  wire logic              hwrite,      // write when high
  input  wire logic [2:0]        hsize,       // transfer size
  input  wire logic [31:0]       hwdata,      // write data
  input  wire logic              hready,      // bus ready in
  output logic                   hreadyout,   // slave ready
  output logic                   hresp,       // always okay
  output logic [31:0]            hrdata,      // read data
  input  wire logic [TRIG_W-1:0] trig_in,     // monitored trigger bus
  output logic                   trig_fire,   // one-cycle chain complete
  output logic                   post_sample  // post-trigger sampling active
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  logic              wr_pend_q;
  logic [11:0]       wr_addr_q;
  logic              rd_pend_q;
  logic [11:0]       rd_addr_q;
  logic [31:0]       hrdata_q;
  logic              addr_ok;
  logic              wr_hit;
  logic [TRIG_W-1:0] mask_q [STM_NUM_PAT][3];
  logic [1:0]        len_q;
  logic [2:0]        or_q;
  logic              seen_q;
  stm_state_t        state_q;
  logic [1:0]        stage_q;

  // hsize ignored: only whole words are mapped
  assign addr_ok   = hsel && hready && htrans[1];
  assign hreadyout = !rd_pend_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign wr_hit    = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      rd_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      rd_pend_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        wr_addr_q <= haddr;
        rd_addr_q <= haddr;
      end
    end
  end

  function automatic logic pat_hit(input logic [11:0] a, output logic [1:0] p,
                                   output logic [1:0] m, output logic hi);
    logic [11:0] r;
    r  = a - STM_PAT_BASE;
    p  = r[6:5];
    m  = r[4:3];
    hi = r[2];
    return (a >= STM_PAT_BASE) && (p < 2'(STM_NUM_PAT)) && (m != 2'h3)
           && (r[11:7] == 5'h00) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [TRIG_W-1:0] put_half(input logic [TRIG_W-1:0] old,
                                                 input logic hi,
                                                 input logic [31:0] d);
    logic [63:0] w;
    w = 64'(old);
    if (hi) begin
      w[63:32] = d;
    end else begin
      w[31:0] = d;
    end
    return w[TRIG_W-1:0];
  endfunction

  function automatic logic [31:0] get_half(input logic [TRIG_W-1:0] v, input logic hi);
    logic [63:0] w;
    w = 64'(v);
    return hi ? w[63:32] : w[31:0];
  endfunction

  // read data one wait state later, so a write just before is already seen
  always_ff @(posedge hclk or negedge hresetn) begin
    logic [1:0] p;
    logic [1:0] m;
    logic       hi;
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (rd_pend_q) begin
      if (rd_addr_q == STM_CTRL_OFS) begin
        hrdata_q <= 32'({or_q, len_q, 2'h0});
      end else if (rd_addr_q == STM_STATUS_OFS) begin
        hrdata_q <= 32'({stage_q, 1'b0, seen_q, state_q == STM_DONE, state_q == STM_ARMED});
      end else if (pat_hit(rd_addr_q, p, m, hi)) begin
        hrdata_q <= get_half(mask_q[p][m], hi);
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers
  logic arm_w;
  logic abort_w;
  logic seen_clr_w;

  assign arm_w      = wr_hit && (wr_addr_q == STM_CTRL_OFS) && hwdata[STM_CTRL_ARM_BIT];
  assign abort_w    = wr_hit && (wr_addr_q == STM_CTRL_OFS) && hwdata[STM_CTRL_ABORT_BIT];
  assign seen_clr_w = wr_hit && (wr_addr_q == STM_STATUS_OFS) && hwdata[STM_STAT_SEEN_BIT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      len_q <= STM_LEN_RST;
      or_q  <= STM_OR_RST;
    end else if (wr_hit && (wr_addr_q == STM_CTRL_OFS)) begin
      len_q <= hwdata[STM_CTRL_LEN_LSB +: 2];
      or_q  <= hwdata[STM_CTRL_OR_LSB +: 3];
    end
  end

  // reset leaves every channel don't-care
  for (genvar k = 0; k < STM_NUM_PAT; k++) begin : g_pat
    for (genvar m = 0; m < 3; m++) begin : g_mask
      always_ff @(posedge hclk or negedge hresetn) begin
        logic [1:0] wp;
        logic [1:0] wm;
        logic       wh;
        if (!hresetn) begin
          mask_q[k][m] <= (m == int'(STM_MASK_DC)) ? '1 : '0;
        end else if (wr_hit && pat_hit(wr_addr_q, wp, wm, wh)) begin
          if ((wp == 2'(k)) && (wm == 2'(m))) begin
            mask_q[k][m] <= put_half(mask_q[k][m], wh, hwdata);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pattern evaluation
  logic [TRIG_W-1:0]      prev_q;
  logic                   prev_ok_q;
  logic [TRIG_W-1:0]      rise;
  logic [TRIG_W-1:0]      fall;
  logic [STM_NUM_PAT-1:0] match;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q    <= '0;
      prev_ok_q <= 1'b0;
    end else begin
      prev_q    <= trig_in;
      prev_ok_q <= 1'b1;
    end
  end

  // no edge is claimed before a first real sample exists
  assign rise = trig_in & ~prev_q & {TRIG_W{prev_ok_q}};
  assign fall = ~trig_in & prev_q & {TRIG_W{prev_ok_q}};

  for (genvar k = 0; k < STM_NUM_PAT; k++) begin : g_match
    logic [TRIG_W-1:0] val;
    logic [TRIG_W-1:0] edg;
    logic [TRIG_W-1:0] dc;
    logic [TRIG_W-1:0] cond;
    assign val  = mask_q[k][STM_MASK_VALUE];
    assign edg  = mask_q[k][STM_MASK_EDGE];
    assign dc   = mask_q[k][STM_MASK_DC];
    // bit n of every mask meets channel n
    assign cond = (edg & ((val & rise) | (~val & fall)))
                | (~edg & ~(trig_in ^ val));
    assign match[k] = or_q[k]
                    ? (|(cond & ~dc) || &dc)
                    : &(cond | dc);
  end

  ////////////////////////////////////////////////////////////////////////////
  // chain sequencer
  logic [1:0] last_stage;
  logic       fire_d;
  logic       trig_fire_q;

  // length zero is taken as one
  assign last_stage = (len_q == 2'h0) ? 2'h0 : len_q - 2'h1;
  assign fire_d     = (state_q == STM_ARMED) && match[stage_q] && (stage_q == last_stage)
                      && !arm_w && !abort_w;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= STM_IDLE;
      stage_q <= 2'h0;
    end else if (abort_w) begin
      state_q <= STM_IDLE;
      stage_q <= 2'h0;
    end else if (arm_w) begin
      state_q <= STM_ARMED;
      stage_q <= 2'h0;
    end else begin
      case (state_q)
        STM_ARMED: begin
          if (fire_d) begin
            state_q <= STM_DONE;
          // never step past the last stage, even if the length shrinks while armed
          end else if (match[stage_q] && (stage_q < last_stage)) begin
            stage_q <= stage_q + 2'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_fire_q <= 1'b0;
    end else begin
      trig_fire_q <= fire_d;
    end
  end

  // a fire in the clearing cycle keeps the flag set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_q <= 1'b0;
    end else if (fire_d) begin
      seen_q <= 1'b1;
    end else if (seen_clr_w) begin
      seen_q <= 1'b0;
    end
  end

  assign trig_fire   = trig_fire_q;
  assign post_sample = (state_q == STM_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_fire_after_arm: assert property (
    trig_fire |-> post_sample && $past(state_q == STM_ARMED))
    else $error("fire without armed matcher");

  chk_len_one_stage: assert property (
    (fire_d && len_q == 2'h1) |-> stage_q == 2'h0 && match[0])
    else $error("length one fired past first pattern");

  chk_stage_step: assert property (
    (state_q == STM_ARMED && !arm_w && !abort_w && match[stage_q] && stage_q < last_stage)
      |=> stage_q == $past(stage_q) + 2'h1 ##0 state_q == STM_ARMED)
    else $error("stage did not advance by one");

  chk_all_dc_match: assert property (
    (&mask_q[0][STM_MASK_DC]) |-> match[0])
    else $error("all don't-care pattern missed");

  chk_rise_bit0: assert property (
    (prev_ok_q && !or_q[0] && mask_q[0][STM_MASK_DC] == {{(TRIG_W-1){1'b1}}, 1'b0}
      && mask_q[0][STM_MASK_EDGE][0] && mask_q[0][STM_MASK_VALUE][0])
      |-> match[0] == (trig_in[0] && !$past(trig_in[0])))
    else $error("rising edge mismatch on channel 0");

  chk_fall_bit0: assert property (
    (prev_ok_q && !or_q[0] && mask_q[0][STM_MASK_DC] == {{(TRIG_W-1){1'b1}}, 1'b0}
      && mask_q[0][STM_MASK_EDGE][0] && !mask_q[0][STM_MASK_VALUE][0])
      |-> match[0] == (!trig_in[0] && $past(trig_in[0])))
    else $error("falling edge mismatch on channel 0");

  chk_level_bit0: assert property (
    (mask_q[0][STM_MASK_DC] == {{(TRIG_W-1){1'b1}}, 1'b0} && !mask_q[0][STM_MASK_EDGE][0])
      |-> match[0] == (trig_in[0] == mask_q[0][STM_MASK_VALUE][0]))
    else $error("level mismatch on channel 0");

  chk_and_miss: assert property (
    (!or_q[1] && |(~mask_q[1][STM_MASK_DC] & ~mask_q[1][STM_MASK_EDGE]
      & (trig_in ^ mask_q[1][STM_MASK_VALUE]))) |-> !match[1])
    else $error("and pattern matched with a failing channel");

  chk_or_none: assert property (
    (or_q[2] && !(&mask_q[2][STM_MASK_DC])
      && ~|(~mask_q[2][STM_MASK_DC] & mask_q[2][STM_MASK_EDGE])
      && ~|(~mask_q[2][STM_MASK_DC] & ~(trig_in ^ mask_q[2][STM_MASK_VALUE]))) |-> !match[2])
    else $error("or pattern matched with no channel");

  chk_read_wait: assert property (
    (addr_ok && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  cov_fire_len3: cover property (fire_d && len_q == 2'h3);
  cov_fire_len1: cover property (fire_d && len_q == 2'h1);
  cov_or_fire:   cover property (fire_d && or_q[last_stage]);
  cov_rearm:     cover property (post_sample ##1 arm_w);

endmodule

//--- include/stm_pkg.sv
// shared constants and types of the sequential trigger matcher
package stm_pkg;

  // register byte offsets
  localparam logic [11:0] STM_CTRL_OFS    = 12'h000;
  localparam logic [11:0] STM_STATUS_OFS  = 12'h004;
  localparam logic [11:0] STM_PAT_BASE    = 12'h020;
  localparam logic [11:0] STM_PAT_STRIDE  = 12'h020;
  localparam logic [11:0] STM_MASK_STRIDE = 12'h008;
  localparam logic [11:0] STM_HI_OFS      = 12'h004;

  // mask selectors inside one pattern
  localparam logic [1:0] STM_MASK_VALUE = 2'h0;
  localparam logic [1:0] STM_MASK_EDGE  = 2'h1;
  localparam logic [1:0] STM_MASK_DC    = 2'h2;

  // control register fields
  localparam int STM_CTRL_ARM_BIT   = 0;
  localparam int STM_CTRL_ABORT_BIT = 1;
  localparam int STM_CTRL_LEN_LSB   = 2;
  localparam int STM_CTRL_OR_LSB    = 4;

  // status register fields
  localparam int STM_STAT_ARMED_BIT = 0;
  localparam int STM_STAT_DONE_BIT  = 1;
  localparam int STM_STAT_SEEN_BIT  = 2;
  localparam int STM_STAT_STAGE_LSB = 4;

  // values after reset
  localparam logic [1:0] STM_LEN_RST = 2'h1;
  localparam logic [2:0] STM_OR_RST  = 3'h0;

  // counts
  localparam int STM_NUM_PAT   = 3;
  localparam int STM_MAX_WIDTH = 40;

  typedef enum logic [1:0] {
    STM_IDLE,
    STM_ARMED,
    STM_DONE
  } stm_state_t;

endpackage

//--- sim/stm_trig_src.sv
// user-design trigger source model feeding the monitored bus
module stm_trig_src #(
  parameter int W = 40
) (
  input  wire logic         clk,  // monitored design clock
  input  wire logic [W-1:0] nxt,  // vector wanted next cycle
  output logic      [W-1:0] trig  // monitored trigger bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // user logic is flopped on the same clock, so lines move only after an edge
  always_ff @(posedge clk) trig <= nxt;
endmodule

//--- sim/tb_sequential_trigger_matcher.sv
// self-checking bench of the sequential trigger matcher
module tb_sequential_trigger_matcher import stm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, trig_fire, post_sample;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd, g;
  logic [39:0] nxt, trig;
  int          n_errors, check_count;

  stm_trig_src #(.W(40)) src (.clk(hclk), .nxt(nxt), .trig(trig));
  stm_matcher #(.TRIG_W(40)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(trig),
    .trig_fire(trig_fire), .post_sample(post_sample));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // look before the edge: hready and hrdata are settled there, no race
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b1;
    wait_rdy(rd);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy(rd);
  endtask

  task automatic rdw(input logic [11:0] a, output logic [31:0] d);
    hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= 1'b0;
    wait_rdy(d);
    hsel <= 1'b0; htrans <= 2'h0;
    wait_rdy(d);
  endtask

  task automatic pat(input int k, input logic [39:0] v, input logic [39:0] e,
                     input logic [39:0] d);
    logic [11:0] b;
    logic [39:0] x[3];
    b = STM_PAT_BASE + STM_PAT_STRIDE * 12'(k);
    x = '{v, e, d};
    for (int m = 0; m < 3; m++) begin
      wr(b + STM_MASK_STRIDE * 12'(m), x[m][31:0]);
      wr(b + STM_MASK_STRIDE * 12'(m) + STM_HI_OFS, {24'h0, x[m][39:32]});
    end
  endtask

  task automatic arm(input logic [1:0] len, input logic [2:0] orb, input logic [1:0] op);
    wr(STM_CTRL_OFS, {25'h0, orb, len, op});
  endtask

  // counts fire pulses over n cycles
  task automatic fire(input int n, output logic [31:0] c);
    c = '0;
    repeat (n) begin
      @(negedge hclk);
      if (trig_fire === 1'b1) c++;
      @(posedge hclk);
    end
  endtask

  // post_sample looked at mid-cycle, clear of the edge that moves it
  task automatic look_ps(output logic [31:0] v);
    @(negedge hclk);
    v = {31'h0, post_sample};
    @(posedge hclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; nxt = '0; n_errors = 0; check_count = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdw(STM_CTRL_OFS, rd);  chk(rd, 32'h4);
    rdw(STM_STATUS_OFS, rd); chk(rd, 32'h0);
    rdw(STM_PAT_BASE + 12'h010, rd); chk(rd, 32'hffffffff);
    rdw(STM_PAT_BASE + 12'h014, rd); chk(rd, 32'h000000ff);
    wr(STM_PAT_BASE + 12'h04c, 32'hffffffff);
    rdw(STM_PAT_BASE + 12'h04c, rd); chk(rd, 32'h000000ff);
    rdw(12'hffc, rd); chk(rd, 32'h0);
    // immediate capture: every pattern still all don't-care
    arm(2'h3, 3'h0, 2'h1); fire(8, g); chk(g, 32'h1);
    fire(8, g); chk(g, 32'h0);
    rdw(STM_STATUS_OFS, rd); chk(rd & 32'h7, 32'h6);
    pat(1, 40'h0, 40'h0, 40'hffffffffff);
    // level and combine: channels 0 and 39 high
    pat(0, 40'h8000000001, 40'h0, 40'h7ffffffffe);
    nxt <= 40'h1;
    arm(2'h1, 3'h0, 2'h1); fire(8, g); chk(g, 32'h0);
    nxt <= 40'h8000000001; fire(8, g); chk(g, 32'h1);
    nxt <= 40'h1;
    arm(2'h1, 3'h1, 2'h1); fire(8, g); chk(g, 32'h1);
    arm(2'h1, 3'h6, 2'h1); fire(8, g); chk(g, 32'h0);
    // edges on channel 0: a held level alone must not count
    for (int i = 0; i < 2; i++) begin
      pat(0, (i == 0) ? 40'h1 : 40'h0, 40'h1, ~40'h1);
      nxt <= (i == 0) ? 40'h1 : 40'h0;
      arm(2'h1, 3'h0, 2'h1); fire(6, g); chk(g, 32'h0);
      nxt <= ~nxt;
      @(posedge hclk);
      nxt <= ~nxt;
      fire(8, g); chk(g, 32'h1);
    end
    pat(0, 40'h1, 40'h0, ~40'h1);
    pat(1, 40'h2, 40'h0, ~40'h2);
    pat(2, 40'h4, 40'h0, ~40'h4);
    nxt <= 40'h6;
    arm(2'h1, 3'h0, 2'h1); fire(8, g); chk(g, 32'h0);
    // length zero behaves as length one
    arm(2'h0, 3'h0, 2'h1); nxt <= 40'h1;
    fire(8, g); chk(g, 32'h1);
    nxt <= 40'h6;
    arm(2'h3, 3'h4, 2'h1); nxt <= 40'h1;
    fire(6, g); chk(g, 32'h0);
    look_ps(g); chk(g, 32'h0);
    rdw(STM_STATUS_OFS, rd); chk(rd & 32'h33, 32'h11);
    nxt <= 40'h2; fire(6, g); chk(g, 32'h0);
    nxt <= 40'h4; fire(6, g); chk(g, 32'h1);
    look_ps(g); chk(g, 32'h1);
    arm(2'h2, 3'h0, 2'h1); nxt <= 40'h1;
    fire(6, g); chk(g, 32'h0);
    nxt <= 40'h2; fire(6, g); chk(g, 32'h1);
    // repetitive records: re-arm with unchanged patterns
    nxt <= 40'h7;
    for (int r = 0; r < 3; r++) begin
      arm(2'h3, 3'h0, 2'h1); fire(10, g); chk(g, 32'h1);
    end
    nxt <= 40'h0;
    arm(2'h3, 3'h0, 2'h1); arm(2'h3, 3'h0, 2'h2);
    look_ps(g); chk(g, 32'h0);
    // sticky seen flag drops on a write of one
    wr(STM_STATUS_OFS, 32'h4);
    rdw(STM_STATUS_OFS, rd); chk(rd & 32'h7, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    print_verdict();
  end
endmodule
